// ===== msp_device.sv
// Device end: frame stream ports, timed streams, timing and interrupts.
//
// Function
// - One stream clock times four frame streams.
// - Transmit data: valid, last, keep, word; ready.
// - Separate transmit control stream, same signals.
// - Receive data stream driven by device; sink ready.
// - Separate receive status stream with sink ready.
// - Each frame stream has its own reset.
// - Device clocks timed transmit stream, returns ready.
// - Timed receive stream has no ready; accept all.
// - Receive user flag low good, high bad.
// - Tick interrupt pulses every 10 ms.
// - Transmit timed-packet interrupt after packet sent.
// - Host records transmit timestamp after interrupt.
// - Receive timed-packet interrupt; host records timestamp.
// - Real-time clock: 32-bit ns, 48-bit seconds.
// - 8 kHz cycle clock locked to real-time clock.
// - One subsystem interrupt output.
`timescale 1ns/1ps
`include "msp_cfg.svh"
module msp_device (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	msp_if.dev                          port,
	// User side: frames leaving on the transmit streams.
	output msp_pkg::msp_beat_t          u_txd,
	output logic                        u_txd_valid,
	output msp_pkg::msp_beat_t          u_txc,
	output logic                        u_txc_valid,
	// User side: frames to present on the receive streams.
	input  wire logic                   u_rxd_valid,
	input  wire msp_pkg::msp_beat_t     u_rxd,
	output logic                        u_rxd_ready,
	input  wire logic                   u_rxs_valid,
	input  wire msp_pkg::msp_beat_t     u_rxs,
	output logic                        u_rxs_ready,
	// User side: timed transmit bytes taken from the fabric.
	output msp_pkg::msp_av_beat_t       u_av_tx,
	output logic                        u_av_tx_valid,
	// User side: timed receive bytes and frame verdict (1 = bad).
	input  wire logic                   u_av_rx_valid,
	input  wire logic [7:0]             u_av_rx_data,
	input  wire logic                   u_av_rx_last,
	input  wire logic                   u_av_rx_bad,
	// User side: timed packets left / passed the packet buffers.
	input  wire logic                   u_ptp_tx_done,
	input  wire logic                   u_ptp_rx_done,
	// User side: real-time clock load.
	input  wire logic                   u_rtc_load,
	input  wire logic [47:0]            u_rtc_sec
);
	// ****************************************************************
	// Local state
	// ****************************************************************
	logic [15:0] iso_cnt_r;     // Cycles within one isochronous cycle.
	logic [7:0]  tick_cnt_r;    // Isochronous cycles within one tick.
	logic [1:0]  av_div_r;      // Divider for the timed stream clocks.
	logic        av_clk_r;      // Divided timed stream clock.
	logic        av_rise;       // Divided clock is about to rise.
	logic        av_rx_pend_r;  // A timed receive byte awaits its beat.
	msp_pkg::msp_av_beat_t av_rx_hold_r; // Byte waiting for the beat.

	// ****************************************************************
	// Frame transmit streams
	// ****************************************************************
	// Ready is held high out of reset; each stream has its own reset.
	always_ff @(posedge port.stream_clk or negedge port.txd_rstn) begin
		if (!port.txd_rstn) begin
			port.txd_ready <= 1'b0;
			u_txd_valid    <= 1'b0;
			u_txd          <= '0;
		end else begin
			port.txd_ready <= 1'b1;
			// A word transfers when valid and ready are both high.
			u_txd_valid <= port.txd_valid & port.txd_ready;
			if (port.txd_valid & port.txd_ready) begin
				u_txd <= port.txd;
			end
		end
	end

	// Transmit control stream, fully separate from transmit data.
	always_ff @(posedge port.stream_clk or negedge port.txc_rstn) begin
		if (!port.txc_rstn) begin
			port.txc_ready <= 1'b0;
			u_txc_valid    <= 1'b0;
			u_txc          <= '0;
		end else begin
			port.txc_ready <= 1'b1;
			u_txc_valid <= port.txc_valid & port.txc_ready;
			if (port.txc_valid & port.txc_ready) begin
				u_txc <= port.txc;
			end
		end
	end

	// ****************************************************************
	// Frame receive streams
	// ****************************************************************
	// One-stage register slice: a beat is held until the sink takes it.
	assign u_rxd_ready = !port.rxd_valid | port.rxd_ready;
	always_ff @(posedge port.stream_clk or negedge port.rxd_rstn) begin
		if (!port.rxd_rstn) begin
			port.rxd_valid <= 1'b0;
			port.rxd       <= '0;
		end else if (u_rxd_ready) begin
			port.rxd_valid <= u_rxd_valid;
			port.rxd       <= u_rxd;
		end
	end

	// Receive status slice, separate from the data stream.
	assign u_rxs_ready = !port.rxs_valid | port.rxs_ready;
	always_ff @(posedge port.stream_clk or negedge port.rxs_rstn) begin
		if (!port.rxs_rstn) begin
			port.rxs_valid <= 1'b0;
			port.rxs       <= '0;
		end else if (u_rxs_ready) begin
			port.rxs_valid <= u_rxs_valid;
			port.rxs       <= u_rxs;
		end
	end

	// ****************************************************************
	// Timed stream clocks
	// ****************************************************************
	// The timed streams run on a clock divided down from clk.
	assign av_rise = (av_div_r == 2'(`MSP_AV_HALF - 1)) && !av_clk_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			av_div_r <= '0;
			av_clk_r <= 1'b0;
		end else if (av_div_r == 2'(`MSP_AV_HALF - 1)) begin
			av_div_r <= '0;
			av_clk_r <= !av_clk_r;
		end else begin
			av_div_r <= av_div_r + 2'h1;
		end
	end
	assign port.av_tx_clk = av_clk_r;
	assign port.av_rx_clk = av_clk_r;

	// Timed transmit: sampled in clk just before the divided clock rises,
	// so the handshake coincides with the fabric's edge.
	always_ff @(posedge clk or negedge port.av_tx_rstn) begin
		if (!port.av_tx_rstn) begin
			port.av_tx_ready <= 1'b0;
			u_av_tx_valid    <= 1'b0;
			u_av_tx          <= '0;
		end else begin
			port.av_tx_ready <= 1'b1;
			u_av_tx_valid <= av_rise & port.av_tx_valid
				& port.av_tx_ready;
			if (av_rise & port.av_tx_valid) begin
				u_av_tx <= port.av_tx;
			end
		end
	end

	// Timed receive: a user byte is held and launched on the next
	// divided edge; the sink has no ready so every beat is final.
	always_ff @(posedge clk or negedge port.av_rx_rstn) begin
		if (!port.av_rx_rstn) begin
			av_rx_pend_r     <= 1'b0;
			av_rx_hold_r     <= '0;
			port.av_rx_valid <= 1'b0;
			port.av_rx       <= '0;
		end else begin
			if (u_av_rx_valid) begin
				av_rx_pend_r      <= 1'b1;
				av_rx_hold_r.data <= u_av_rx_data;
				av_rx_hold_r.last <= u_av_rx_last;
				// Flag low for good, high for bad, on the last beat.
				av_rx_hold_r.user <= u_av_rx_last & u_av_rx_bad;
			end else if (av_rise) begin
				av_rx_pend_r <= 1'b0;
			end
			if (av_rise) begin
				port.av_rx_valid <= av_rx_pend_r;
				port.av_rx       <= av_rx_hold_r;
			end
		end
	end

	// ****************************************************************
	// Real-time clock and cycle clock
	// ****************************************************************
	// Nanoseconds advance by one period each cycle, rolling into seconds.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port.rtc_ns  <= '0;
			port.rtc_sec <= '0;
		end else if (u_rtc_load) begin
			port.rtc_ns  <= '0;
			port.rtc_sec <= u_rtc_sec;
		end else if (port.rtc_ns >= 32'(`MSP_NS_PER_SEC - `MSP_CLK_NS)) begin
			port.rtc_ns  <= '0;
			port.rtc_sec <= port.rtc_sec + 48'h1;
		end else begin
			port.rtc_ns <= port.rtc_ns + 32'(`MSP_CLK_NS);
		end
	end

	// The cycle clock is high for the first half of each 125 us cycle
	// and restarts with the real-time clock, keeping it phase-locked.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			iso_cnt_r                    <= '0;
			port.isochronous_cycle_clock <= 1'b0;
		end else begin
			if (u_rtc_load || iso_cnt_r == 16'(`MSP_ISO_CYC - 1)) begin
				iso_cnt_r <= '0;
			end else begin
				iso_cnt_r <= iso_cnt_r + 16'h1;
			end
			port.isochronous_cycle_clock <=
				(iso_cnt_r < 16'(`MSP_ISO_CYC / 2));
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	// Tick pulses one cycle every 80 isochronous cycles (10 ms).
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_r    <= '0;
			port.irq_tick <= 1'b0;
		end else begin
			port.irq_tick <= 1'b0;
			if (u_rtc_load) begin
				tick_cnt_r <= '0;
			end else if (iso_cnt_r == 16'(`MSP_ISO_CYC - 1)) begin
				if (tick_cnt_r == 8'(`MSP_TICK_ISO - 1)) begin
					tick_cnt_r    <= '0;
					port.irq_tick <= 1'b1;
				end else begin
					tick_cnt_r <= tick_cnt_r + 8'h1;
				end
			end
		end
	end

	// Packet interrupts pulse after the packet buffers report a packet;
	// the subsystem line is the OR of all events, one cycle later.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port.irq_ptp_tx <= 1'b0;
			port.irq_ptp_rx <= 1'b0;
			port.irq_sys    <= 1'b0;
		end else begin
			port.irq_ptp_tx <= u_ptp_tx_done;
			port.irq_ptp_rx <= u_ptp_rx_done;
			port.irq_sys <= port.irq_tick | port.irq_ptp_tx
				| port.irq_ptp_rx;
		end
	end
endmodule

// ===== msp_cfg.svh
// Timing and layout constants shared by both ends of the port layer.
`ifndef MSP_CFG_SVH
`define MSP_CFG_SVH
// ****************************************************************
// Clock and timing
// ****************************************************************
// Clock rate in MHz.
`define MSP_CLK_MHZ        200
// Nanoseconds per clock period.
`define MSP_CLK_NS         5
// Tick interrupt period in milliseconds.
`define MSP_TICK_MS        10
// Isochronous cycle period in microseconds.
`define MSP_ISO_US         125
// Clock cycles in one isochronous cycle.
`define MSP_ISO_CYC        (`MSP_ISO_US * `MSP_CLK_MHZ)
// Isochronous cycles per tick interrupt.
`define MSP_TICK_ISO       ((`MSP_TICK_MS * 1000) / `MSP_ISO_US)
// Nanoseconds per second.
`define MSP_NS_PER_SEC     1000000000
// Divide ratio of the timed stream clocks (half period in cycles).
`define MSP_AV_HALF        2
// ****************************************************************
// Stream widths
// ****************************************************************
// Frame stream data width.
`define MSP_WORD_W         32
// Frame stream strobe width.
`define MSP_KEEP_W         4
// Timed stream byte width.
`define MSP_AV_W           8
// Full-word strobe value.
`define MSP_KEEP_ALL       4'hF
`endif

// ===== msp_pkg.sv
// Types shared by both ends of the port layer.
package msp_pkg;
	// One beat of a 32-bit frame stream.
	typedef struct packed {
		logic [31:0] data;
		logic [3:0]  keep;
		logic        last;
	} msp_beat_t;
	// One beat of an 8-bit timed stream.
	typedef struct packed {
		logic [7:0] data;
		logic       user;
		logic       last;
	} msp_av_beat_t;
endpackage

// ===== msp_if.sv
// Interface joining the device end and the fabric end of the port layer.
`timescale 1ns/1ps
interface msp_if;
	logic                 stream_clk;    // Clock of the four frame streams.
	logic                 txd_rstn;      // Transmit data stream reset.
	logic                 txc_rstn;      // Transmit control stream reset.
	logic                 rxd_rstn;      // Receive data stream reset.
	logic                 rxs_rstn;      // Receive status stream reset.
	msp_pkg::msp_beat_t   txd;           // Transmit data beat.
	logic                 txd_valid;     // Transmit data valid.
	logic                 txd_ready;     // Transmit data ready.
	msp_pkg::msp_beat_t   txc;           // Transmit control beat.
	logic                 txc_valid;     // Transmit control valid.
	logic                 txc_ready;     // Transmit control ready.
	msp_pkg::msp_beat_t   rxd;           // Receive data beat.
	logic                 rxd_valid;     // Receive data valid.
	logic                 rxd_ready;     // Receive data ready.
	msp_pkg::msp_beat_t   rxs;           // Receive status beat.
	logic                 rxs_valid;     // Receive status valid.
	logic                 rxs_ready;     // Receive status ready.
	logic                 av_tx_clk;     // Timed transmit clock.
	logic                 av_tx_rstn;    // Timed transmit reset.
	msp_pkg::msp_av_beat_t av_tx;        // Timed transmit beat.
	logic                 av_tx_valid;   // Timed transmit valid.
	logic                 av_tx_ready;   // Timed transmit ready.
	logic                 av_rx_clk;     // Timed receive clock.
	logic                 av_rx_rstn;    // Timed receive reset.
	msp_pkg::msp_av_beat_t av_rx;        // Timed receive beat.
	logic                 av_rx_valid;   // Timed receive valid.
	logic                 irq_tick;      // Periodic tick interrupt.
	logic                 irq_ptp_tx;    // Timed packet sent interrupt.
	logic                 irq_ptp_rx;    // Timed packet received interrupt.
	logic                 irq_sys;       // Subsystem interrupt.
	logic [31:0]          rtc_ns;        // Real-time clock nanoseconds.
	logic [47:0]          rtc_sec;       // Real-time clock seconds.
	logic                 isochronous_cycle_clock; // 8 kHz cycle clock.

	// Documented device end.
	modport dev (
		input  stream_clk, txd_rstn, txc_rstn, rxd_rstn, rxs_rstn,
		input  txd, txd_valid, txc, txc_valid, rxd_ready, rxs_ready,
		output txd_ready, txc_ready, rxd, rxd_valid, rxs, rxs_valid,
		output av_tx_clk, av_tx_ready, av_rx_clk, av_rx, av_rx_valid,
		input  av_tx_rstn, av_rx_rstn, av_tx, av_tx_valid,
		output irq_tick, irq_ptp_tx, irq_ptp_rx, irq_sys,
		output rtc_ns, rtc_sec, isochronous_cycle_clock
	);
	// Fabric end.
	modport fab (
		output stream_clk, txd_rstn, txc_rstn, rxd_rstn, rxs_rstn,
		output txd, txd_valid, txc, txc_valid, rxd_ready, rxs_ready,
		input  txd_ready, txc_ready, rxd, rxd_valid, rxs, rxs_valid,
		input  av_tx_clk, av_tx_ready, av_rx_clk, av_rx, av_rx_valid,
		output av_tx_rstn, av_rx_rstn, av_tx, av_tx_valid,
		input  irq_tick, irq_ptp_tx, irq_ptp_rx, irq_sys,
		input  rtc_ns, rtc_sec, isochronous_cycle_clock
	);
endinterface

// ===== msp_fabric.sv
// Fabric end: feeds the transmit streams and drains the receive streams.
`timescale 1ns/1ps
`include "msp_cfg.svh"
module msp_fabric (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	msp_if.fab                          port,
	// User side: transmit data request.
	input  wire logic                   u_txd_valid,
	input  wire msp_pkg::msp_beat_t     u_txd,
	output logic                        u_txd_ready,
	// User side: transmit control request.
	input  wire logic                   u_txc_valid,
	input  wire msp_pkg::msp_beat_t     u_txc,
	output logic                        u_txc_ready,
	// User side: received data and status.
	output msp_pkg::msp_beat_t          u_rxd,
	output logic                        u_rxd_valid,
	output msp_pkg::msp_beat_t          u_rxs,
	output logic                        u_rxs_valid,
	// User side: timed transmit byte request.
	input  wire logic                   u_av_valid,
	input  wire msp_pkg::msp_av_beat_t  u_av,
	output logic                        u_av_ready,
	// User side: timed received byte and good/bad verdict.
	output msp_pkg::msp_av_beat_t       u_av_rx,
	output logic                        u_av_rx_valid,
	// User side: timestamp capture demands and the subsystem interrupt.
	output logic                        u_tx_stamp,
	output logic                        u_rx_stamp,
	output logic                        u_irq
);
	// ****************************************************************
	// Streams clock and resets
	// ****************************************************************
	// The frame streams run on this end's clock; all resets follow rstn.
	assign port.stream_clk = clk;
	assign port.txd_rstn   = rstn;
	assign port.txc_rstn   = rstn;
	assign port.rxd_rstn   = rstn;
	assign port.rxs_rstn   = rstn;
	assign port.av_tx_rstn = rstn;
	assign port.av_rx_rstn = rstn;

	// Transmit sides pass through: the user keeps a beat until ready.
	assign port.txd_valid = u_txd_valid;
	assign port.txd       = u_txd;
	assign u_txd_ready    = port.txd_ready;
	assign port.txc_valid = u_txc_valid;
	assign port.txc       = u_txc;
	assign u_txc_ready    = port.txc_ready;
	assign port.av_tx_valid = u_av_valid;
	assign port.av_tx       = u_av;
	assign u_av_ready       = port.av_tx_ready;

	// Receive sinks are always ready and capture each beat taken.
	assign port.rxd_ready = 1'b1;
	assign port.rxs_ready = 1'b1;

	// ****************************************************************
	// Receive capture
	// ****************************************************************
	// Registers each accepted receive data and status beat.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			u_rxd       <= '0;
			u_rxd_valid <= 1'b0;
			u_rxs       <= '0;
			u_rxs_valid <= 1'b0;
		end else begin
			u_rxd_valid <= port.rxd_valid;
			u_rxs_valid <= port.rxs_valid;
			if (port.rxd_valid) begin
				u_rxd <= port.rxd;
			end
			if (port.rxs_valid) begin
				u_rxs <= port.rxs;
			end
		end
	end

	// Timed receive beats are taken on every beat, never refused.
	always_ff @(negedge port.av_rx_clk or negedge rstn) begin
		if (!rstn) begin
			u_av_rx       <= '0;
			u_av_rx_valid <= 1'b0;
		end else begin
			u_av_rx_valid <= port.av_rx_valid;
			if (port.av_rx_valid) begin
				u_av_rx <= port.av_rx;
			end
		end
	end

	// Timestamp interrupts become capture demands for the user.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			u_tx_stamp <= 1'b0;
			u_rx_stamp <= 1'b0;
			u_irq      <= 1'b0;
		end else begin
			u_tx_stamp <= port.irq_ptp_tx;
			u_rx_stamp <= port.irq_ptp_rx;
			u_irq      <= port.irq_sys;
		end
	end
endmodule

// ===== msp_sva.sv
// Checker for the interface joining the two ends of the port layer.
`timescale 1ns/1ps
`include "msp_cfg.svh"
module msp_sva (
	input wire logic                  stream_clk,
	input wire logic                  txd_rstn,
	input wire msp_pkg::msp_beat_t    rxd,
	input wire logic                  rxd_valid,
	input wire msp_pkg::msp_beat_t    rxs,
	input wire logic                  rxs_valid,
	input wire logic                  av_tx_clk,
	input wire logic                  av_rx_clk,
	input wire msp_pkg::msp_av_beat_t av_rx,
	input wire logic                  av_rx_valid,
	input wire logic                  irq_tick,
	input wire logic                  irq_ptp_tx,
	input wire logic                  irq_ptp_rx,
	input wire logic                  irq_sys,
	input wire logic [31:0]           rtc_ns,
	input wire logic [47:0]           rtc_sec,
	input wire logic                  isochronous_cycle_clock
);
	// ****
	// Helper logic
	// ****
	localparam int ISO_HALF = `MSP_ISO_CYC / 2; // Cycles per half period.
	logic        iso_prev_r; // Cycle clock one edge ago.
	logic [15:0] iso_cnt_r;  // Edges since the cycle clock last moved.
	default clocking @(posedge stream_clk); endclocking
	default disable iff (!txd_rstn);
	// Counts edges since the cycle clock moved or restarted.
	always_ff @(posedge stream_clk or negedge txd_rstn) begin
		if (!txd_rstn) begin
			iso_prev_r <= 1'h0;
			iso_cnt_r <= 16'h0;
		end else begin
			iso_prev_r <= isochronous_cycle_clock;
			if (isochronous_cycle_clock != iso_prev_r
				|| rtc_ns == 32'h5) begin
				iso_cnt_r <= 16'h0;
			end else begin
				iso_cnt_r <= iso_cnt_r + 16'h1;
			end
		end
	end
	// ****
	// Properties
	// ****
	property p_rxd_keep;
		rxd_valid && !rxd.last |-> rxd.keep == 4'hF;
	endproperty
	a_rxd_keep: assert property (p_rxd_keep)
		else $error("Partial data strobes before the last word.");
	property p_rxs_keep;
		rxs_valid && !rxs.last |-> rxs.keep == 4'hF;
	endproperty
	a_rxs_keep: assert property (p_rxs_keep)
		else $error("Partial status strobes before the last word.");
	property p_avrx_user;
		av_rx_valid && !av_rx.last |-> !av_rx.user;
	endproperty
	a_avrx_user: assert property (p_avrx_user)
		else $error("Bad flag raised on a word that is not last.");
	property p_av_clk;
		$rose(av_tx_clk) |-> av_tx_clk[*2] ##1 !av_tx_clk[*2] ##1 av_tx_clk;
	endproperty
	a_av_clk: assert property (p_av_clk)
		else $error("Timed transmit clock lost its shape.");
	property p_avrx_rise;
		$rose(av_rx_valid) |-> $rose(av_rx_clk) ##0 av_rx_valid[*4];
	endproperty
	a_avrx_rise: assert property (p_avrx_rise)
		else $error("Timed receive byte not aligned to one clock period.");
	property p_sys_cause;
		irq_sys |-> $past(irq_ptp_tx) || $past(irq_ptp_rx) || $past(irq_tick);
	endproperty
	a_sys_cause: assert property (p_sys_cause)
		else $error("Subsystem interrupt without a cause one cycle before.");
	property p_ptp_pulse;
		irq_ptp_tx || irq_ptp_rx |=> !irq_ptp_tx && !irq_ptp_rx ##0 irq_sys;
	endproperty
	a_ptp_pulse: assert property (p_ptp_pulse)
		else $error("Packet interrupt not a pulse or not forwarded.");
	property p_rtc_ns;
		rtc_ns != 32'h3B9A_C9FB |=> rtc_ns == $past(rtc_ns) + 32'h5
			|| rtc_ns == 32'h0;
	endproperty
	a_rtc_ns: assert property (p_rtc_ns)
		else $error("Nanosecond field did not advance by one period.");
	property p_sec_hold;
		rtc_ns != 32'h0 |-> $stable(rtc_sec);
	endproperty
	a_sec_hold: assert property (p_sec_hold)
		else $error("Seconds field moved away from a wrap or load.");
	property p_iso_max;
		iso_cnt_r < 16'(ISO_HALF);
	endproperty
	a_iso_max: assert property (p_iso_max)
		else $error("Cycle clock stood longer than half its period.");
	c_ptp_rx: cover property (irq_ptp_rx);
	c_rx_last: cover property (rxd_valid && rxd.last);
	c_av_bad: cover property (av_rx_valid && av_rx.user);
endmodule

// ===== tb_top.sv
// Testbench joining both ends of the port layer and checking them.
`timescale 1ns/1ps
`include "msp_cfg.svh"
module tb_top;
	// ****
	// Signals and instances
	// ****
	logic                  clk = 1'h0;             // Stream clock.
	logic                  rstn = 1'h0;            // Reset, active low.
	int                    fails = 0;              // Mismatches seen.
	int                    samples_checked = 0;    // Comparisons made.
	logic                  f_txd_v = 1'h0, f_txc_v = 1'h0, f_av_v = 1'h0;
	msp_pkg::msp_beat_t    f_txd = '0, f_txc = '0; // Fabric requests.
	msp_pkg::msp_av_beat_t f_av = '0, f_avrx, d_av; // Timed bytes.
	logic                  f_txd_r, f_txc_r, f_av_r, f_rxd_v, f_rxs_v;
	logic                  f_avrx_v, f_txs, f_rxst, f_irq; // Fabric flags.
	msp_pkg::msp_beat_t    f_rxd, f_rxs, d_txd, d_txc; // Observed beats.
	logic                  d_txd_v, d_txc_v, d_rxd_r, d_rxs_r, d_av_v;
	msp_pkg::msp_beat_t    d_rxd = '0, d_rxs = '0; // Device receive beats.
	logic                  d_rxd_v = 1'h0, d_rxs_v = 1'h0, d_avrx_v = 1'h0;
	logic                  d_avrx_last = 1'h0, d_avrx_bad = 1'h0;
	logic                  d_ptx = 1'h0, d_prx = 1'h0, d_load = 1'h0;
	logic [7:0]            d_avrx_data = 8'h0;     // Timed receive byte.
	logic [47:0]           d_sec = 48'h0;          // Seconds to load.
	msp_if bus();
	msp_fabric msp_fabric_i (.clk(clk), .rstn(rstn), .port(bus),
		.u_txd_valid(f_txd_v), .u_txd(f_txd), .u_txd_ready(f_txd_r),
		.u_txc_valid(f_txc_v), .u_txc(f_txc), .u_txc_ready(f_txc_r),
		.u_rxd(f_rxd), .u_rxd_valid(f_rxd_v), .u_rxs(f_rxs),
		.u_rxs_valid(f_rxs_v), .u_av_valid(f_av_v), .u_av(f_av),
		.u_av_ready(f_av_r), .u_av_rx(f_avrx), .u_av_rx_valid(f_avrx_v),
		.u_tx_stamp(f_txs), .u_rx_stamp(f_rxst), .u_irq(f_irq));
	msp_device msp_device_i (.clk(clk), .rstn(rstn), .port(bus),
		.u_txd(d_txd), .u_txd_valid(d_txd_v), .u_txc(d_txc),
		.u_txc_valid(d_txc_v), .u_rxd_valid(d_rxd_v), .u_rxd(d_rxd),
		.u_rxd_ready(d_rxd_r), .u_rxs_valid(d_rxs_v), .u_rxs(d_rxs),
		.u_rxs_ready(d_rxs_r), .u_av_tx(d_av), .u_av_tx_valid(d_av_v),
		.u_av_rx_valid(d_avrx_v), .u_av_rx_data(d_avrx_data),
		.u_av_rx_last(d_avrx_last), .u_av_rx_bad(d_avrx_bad),
		.u_ptp_tx_done(d_ptx), .u_ptp_rx_done(d_prx),
		.u_rtc_load(d_load), .u_rtc_sec(d_sec));
	msp_sva msp_sva_i (.stream_clk(bus.stream_clk), .txd_rstn(bus.txd_rstn),
		.rxd(bus.rxd), .rxd_valid(bus.rxd_valid), .rxs(bus.rxs),
		.rxs_valid(bus.rxs_valid), .av_tx_clk(bus.av_tx_clk),
		.av_rx_clk(bus.av_rx_clk), .av_rx(bus.av_rx),
		.av_rx_valid(bus.av_rx_valid), .irq_tick(bus.irq_tick),
		.irq_ptp_tx(bus.irq_ptp_tx), .irq_ptp_rx(bus.irq_ptp_rx),
		.irq_sys(bus.irq_sys), .rtc_ns(bus.rtc_ns), .rtc_sec(bus.rtc_sec),
		.isochronous_cycle_clock(bus.isochronous_cycle_clock));
	// ****
	// Tasks
	// ****
	// Compares one value and counts the outcome.
	task automatic chk(input string nm, input logic [47:0] e,
		input logic [47:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Sends a three-word frame on both transmit streams back to back.
	task automatic t_tx();
		msp_pkg::msp_beat_t b, c;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			if (i > 0) begin
				chk("txd", {10'h0, 1'h1, b}, {10'h0, d_txd_v, d_txd});
				chk("txc", {10'h0, 1'h1, c}, {10'h0, d_txc_v, d_txc});
			end
			b = '{32'hA5C3_0F10 + 32'(i), (i == 2) ? 4'h3 : 4'hF, i == 2};
			c = '{~b.data, b.keep, b.last};
			f_txd = b;
			f_txc = c;
			f_txd_v = (i < 3);
			f_txc_v = (i < 3);
		end
	endtask
	// Presents a three-word frame on both receive streams back to back.
	task automatic t_rx();
		msp_pkg::msp_beat_t b[3], c[3];
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			if (i > 1) begin
				chk("rxd", {10'h0, 1'h1, b[i-2]}, {10'h0, f_rxd_v, f_rxd});
				chk("rxs", {10'h0, 1'h1, c[i-2]}, {10'h0, f_rxs_v, f_rxs});
				chk("rx_ready", 48'h3, {46'h0, d_rxd_r, d_rxs_r});
			end
			if (i < 3) begin
				b[i] = '{32'h5E00_7A00 + 32'(i), (i == 2) ? 4'h1 : 4'hF, i == 2};
				c[i] = '{b[i].data ^ 32'hFFFF_0000, b[i].keep, b[i].last};
			end
			d_rxd = b[i % 3];
			d_rxs = c[i % 3];
			d_rxd_v = (i < 3);
			d_rxs_v = (i < 3);
		end
	endtask
	// Sends two timed bytes, the second marked last with its user bit.
	task automatic t_av_tx();
		for (int i = 0; i < 2; i++) begin
			@(negedge clk);
			f_av = '{8'h3C + 8'(i), i == 1, i == 1};
			f_av_v = 1'h1;
			for (int k = 0; k < 12 && d_av_v !== 1'h1; k++) @(negedge clk);
			chk("av_tx", {37'h0, 1'h1, f_av}, {37'h0, d_av_v, d_av});
			f_av_v = 1'h0;
		end
	endtask
	// Receives three timed bytes: early bad, last good, last bad.
	task automatic t_av_rx();
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			d_avrx_v = 1'h1;
			d_avrx_data = 8'h61 + 8'(i);
			d_avrx_last = (i > 0);
			d_avrx_bad = (i != 1);
			@(negedge clk);
			d_avrx_v = 1'h0;
			for (int k = 0; k < 12 && f_avrx_v !== 1'h1; k++) @(negedge clk);
			chk("av_rx", {37'h0, 1'h1, 8'h61 + 8'(i), i == 2, i > 0},
				{37'h0, f_avrx_v, f_avrx});
			for (int k = 0; k < 12 && f_avrx_v !== 1'h0; k++) @(negedge clk);
		end
	endtask
	// Raises each packet-done event and follows the interrupts.
	task automatic t_ptp();
		for (int i = 0; i < 2; i++) begin
			@(negedge clk);
			d_ptx = (i == 0);
			d_prx = (i == 1);
			@(negedge clk);
			d_ptx = 1'h0;
			d_prx = 1'h0;
			@(negedge clk);
			chk("stamp", {46'h0, i == 0, i == 1}, {46'h0, f_txs, f_rxst});
			@(negedge clk);
			chk("irq", 48'h1, {47'h0, f_irq});
			chk("stamp_end", 48'h0, {46'h0, f_txs, f_rxst});
		end
	endtask
	// Loads the seconds, then times the cycle clock's half periods.
	task automatic t_rtc();
		int   n;
		logic lvl;
		@(negedge clk);
		d_load = 1'h1;
		d_sec = 48'h0000_1234_5678;
		@(negedge clk);
		d_load = 1'h0;
		repeat (3) @(negedge clk);
		chk("rtc_sec", 48'h0000_1234_5678, bus.rtc_sec);
		chk("rtc_ns", 48'hF, {16'h0, bus.rtc_ns});
		for (int j = 0; j < 3; j++) begin
			n = 0;
			lvl = bus.isochronous_cycle_clock;
			while (bus.isochronous_cycle_clock === lvl && n < 30000) begin
				@(negedge clk);
				n++;
			end
			if (j > 0) begin
				chk("iso_half", 48'(`MSP_ISO_CYC / 2), 48'(n));
			end
		end
	endtask
	// ****
	// Clock, sequence and watchdog
	// ****
	// Toggles the clock every half period.
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Resets the block, then runs every scenario.
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'h1;
		repeat (2) @(negedge clk);
		t_tx();
		t_rx();
		t_av_tx();
		t_av_rx();
		t_ptp();
		t_rtc();
		report_and_stop();
	end
	// Cuts a hung run short well after the longest expected span.
	initial begin
		#300000;
		fails++;
		report_and_stop();
	end
endmodule
